/* File: core/cgch_map.svh */
// Offsets, field positions, reset values and counts of the chain group command handler
`ifndef CGCH_MAP_SVH
`define CGCH_MAP_SVH

`define CGCH_CTRL_OFS   16'h0309
`define CGCH_CTRL_RST   8'h00
`define CGCH_DIR_BIT    7
`define CGCH_FT_BIT     7
`define CGCH_REQ_MSB    6
`define CGCH_REQ_LSB    4
`define CGCH_DSZ_MSB    2
`define CGCH_DSZ_LSB    0
`define CGCH_CMD_HDR    9'd3
`define CGCH_OVERHEAD   9'd6
`define CGCH_CRC_INIT   16'hffff
`define CGCH_CRC_DIV    16'hc002

`endif

/* File: core/cgch_pkg.sv */
// Types of the chain group command handler
package cgch_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_HDR  = 4'b0010,
        ST_EXEC = 4'b0100,
        ST_SEND = 4'b1000
    } cgch_state_t;

    typedef enum logic [2:0] {
        RQ_SREAD  = 3'b010,
        RQ_SWRITE = 3'b011,
        RQ_BREAD  = 3'b100,
        RQ_BWRITE = 3'b101,
        RQ_RWRITE = 3'b110
    } cgch_req_t;

    typedef struct packed {
        cgch_state_t     st;
        logic [7:0]      ctrl;
        logic [2:0]      req;
        logic [2:0]      dsz;
        logic            bad;
        logic [8:0]      idx;
        logic [15:0]     raddr;
        logic [7:0]      rdcnt;
        logic [7:0][7:0] wbuf;
        logic [15:0]     crx;
        logic [15:0]     ctx;
        logic            wt;
        logic            rdw;
        logic            dhave;
        logic [7:0]      dbyte;
        logic [8:0]      uidx;
        logic [8:0]      ulen;
        logic [7:0]      uaddr;
        logic [15:0]     ucrc;
        logic            up_rdy;
        logic            wr_en;
        logic [15:0]     wr_addr;
        logic [7:0]      wr_data;
        logic            rd_req;
        logic [15:0]     rd_addr;
        logic            crc_fault;
        logic            comm_err;
    } cgch_regs_t;

endpackage

/* File: core/cgch_crc.sv */
// Byte-wise frame CRC step, bit-stream order
`timescale 1ns/1ps
`include "cgch_map.svh"

module cgch_crc (
    // Running value and byte
    input  wire logic [15:0] i_crc,
    input  wire logic [7:0]  i_byte,
    // Updated value
    output logic      [15:0] o_crc
);
    // Reflected form of the stream-order divisor
    function automatic logic [15:0] refl_poly();
        logic [15:0] f;
        logic [15:0] r;
        f = (`CGCH_CRC_DIV << 1) | 16'h0001;
        r = 16'h0000;
        for (int b = 0; b < 16; b++) begin
            r[b] = f[15 - b];
        end
        return r;
    endfunction

    always_comb begin
        logic [15:0] c;
        c = i_crc ^ {8'h00, i_byte};
        for (int b = 0; b < 8; b++) begin
            if (c[0]) begin
                c = (c >> 1) ^ refl_poly();
            end else begin
                c = c >> 1;
            end
        end
        o_crc = c;
    end

endmodule

/* File: core/cgch_fifo.sv */
// Response byte FIFO with registered output and registered ready
`timescale 1ns/1ps

module cgch_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    // Clock and reset
    input  wire logic         i_mclk,
    input  wire logic         i_rst,
    // Fill side
    input  wire logic         i_in_valid,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_in_ready,
    // Drain side
    output logic              o_out_valid,
    output logic [W-1:0]      o_out_data,
    input  wire logic         i_out_ready
);
    localparam int AW = $clog2(D);
    localparam int CW = AW + 1;

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [CW-1:0]       cnt;
        logic                ov;
        logic [W-1:0]        od;
        logic                rdy;
    } cgch_fifo_t;

    cgch_fifo_t q;
    cgch_fifo_t n;
    logic       push;
    logic       pop;

    always_comb begin
        n    = q;
        push = i_in_valid && (q.cnt != CW'(D));
        pop  = (q.cnt != '0) && (!q.ov || i_out_ready);
        if (q.ov && i_out_ready) begin
            n.ov = 1'b0;
        end
        if (pop) begin
            n.od = q.mem[q.rp];
            n.ov = 1'b1;
            n.rp = q.rp + AW'(1);
        end
        if (push) begin
            n.mem[q.wp] = i_in_data;
            n.wp        = q.wp + AW'(1);
        end
        n.cnt = q.cnt + CW'(push) - CW'(pop);
        // Ready leaves one slot spare since it lags a cycle
        n.rdy = n.cnt < CW'(D - 1);
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign o_in_ready  = q.rdy;
    assign o_out_valid = q.ov;
    assign o_out_data  = q.od;

endmodule

/* File: core/cgch_handler.sv */
// Group command handler of a daisy-chained monitor device
`timescale 1ns/1ps
`include "cgch_map.svh"

module cgch_handler
    import cgch_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    // Chain configuration
    input  wire logic [7:0]  i_dev_addr,
    input  wire logic        i_stack_member,
    input  wire logic        i_top_of_chain,
    // Command bytes from the chain
    input  wire logic        i_cmd_valid,
    input  wire logic        i_cmd_sof,
    input  wire logic [7:0]  i_cmd_data,
    input  wire logic        i_cmd_from_upper,
    // Responses arriving from the device above
    input  wire logic        i_up_valid,
    input  wire logic [7:0]  i_up_data,
    output logic             o_up_ready,
    // Responses toward the host
    output logic             o_rsp_valid,
    output logic [7:0]       o_rsp_data,
    input  wire logic        i_rsp_ready,
    // Register space access
    output logic             o_wr_en,
    output logic [15:0]      o_wr_addr,
    output logic [7:0]       o_wr_data,
    output logic             o_rd_req,
    output logic [15:0]      o_rd_addr,
    input  wire logic        i_rd_valid,
    input  wire logic [7:0]  i_rd_data,
    // Status
    output logic             o_dir_sel,
    output logic             o_crc_fault,
    output logic             o_comm_err
);
    // =========================================================
    // Decoding helpers
    // =========================================================
    function automatic logic is_write(input logic [2:0] r);
        return (r == RQ_SWRITE) || (r == RQ_BWRITE) || (r == RQ_RWRITE);
    endfunction

    function automatic logic is_group(input logic [7:0] b);
        logic [2:0] r;
        r = b[`CGCH_REQ_MSB:`CGCH_REQ_LSB];
        return b[`CGCH_FT_BIT] && (r >= RQ_SREAD) && (r <= RQ_RWRITE);
    endfunction

    // =========================================================
    // State, CRC steps and FIFO
    // =========================================================
    cgch_regs_t  q;
    cgch_regs_t  n;
    logic [15:0] crx_seed;
    logic [15:0] crx_nxt;
    logic [15:0] ucrc_seed;
    logic [15:0] ucrc_nxt;
    logic [15:0] ctx_seed;
    logic [15:0] ctx_nxt;
    logic        fifo_rdy;
    logic        relay;
    logic        own_push;
    logic [7:0]  own_byte;
    logic [8:0]  nd;
    logic [8:0]  cmd_last;
    logic [8:0]  snd_last;
    logic [15:0] daddr;
    logic        indata;
    logic        responder;

    assign crx_seed  = i_cmd_sof ? `CGCH_CRC_INIT : q.crx;
    assign ucrc_seed = (q.uidx == 9'd0) ? `CGCH_CRC_INIT : q.ucrc;
    assign ctx_seed  = (q.idx == 9'd0) ? `CGCH_CRC_INIT : q.ctx;

    cgch_crc u_crc_cmd (
        .i_crc  (crx_seed),
        .i_byte (i_cmd_data),
        .o_crc  (crx_nxt)
    );

    cgch_crc u_crc_up (
        .i_crc  (ucrc_seed),
        .i_byte (i_up_data),
        .o_crc  (ucrc_nxt)
    );

    cgch_crc u_crc_tx (
        .i_crc  (ctx_seed),
        .i_byte (own_byte),
        .o_crc  (ctx_nxt)
    );

    cgch_fifo #(
        .W (8),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .i_mclk      (i_mclk),
        .i_rst       (i_rst),
        .i_in_valid  (own_push || relay),
        .i_in_data   (own_push ? own_byte : i_up_data),
        .o_in_ready  (fifo_rdy),
        .o_out_valid (o_rsp_valid),
        .o_out_data  (o_rsp_data),
        .i_out_ready (i_rsp_ready)
    );

    // =========================================================
    // Next-state logic
    // =========================================================
    always_comb begin
        n           = q;
        n.wr_en     = 1'b0;
        n.rd_req    = 1'b0;
        n.crc_fault = 1'b0;
        n.comm_err  = 1'b0;
        relay       = i_up_valid && q.up_rdy;
        own_push    = 1'b0;
        own_byte    = 8'h00;
        // writes carry size+1 bytes, reads one
        nd          = is_write(q.req) ? 9'({1'b0, q.dsz}) + 9'd1 : 9'd1;
        // no device address byte in the command
        cmd_last    = `CGCH_CMD_HDR + nd + 9'd1;
        snd_last    = 9'({1'b0, q.rdcnt}) + `CGCH_OVERHEAD;
        daddr       = q.raddr + 16'(q.idx - 9'd4);
        indata      = (q.idx >= 9'd4) && (q.idx < snd_last - 9'd1);
        responder   = (q.req == RQ_BREAD) || (q.req == RQ_SREAD && i_stack_member);

        case (q.st)
            ST_EXEC: begin
                if (q.raddr + 16'(q.idx) == `CGCH_CTRL_OFS) begin
                    n.ctrl = q.wbuf[q.idx[2:0]];
                end else begin
                    n.wr_en   = 1'b1;
                    n.wr_addr = q.raddr + 16'(q.idx);
                    n.wr_data = q.wbuf[q.idx[2:0]];
                end
                if (q.idx[2:0] == q.dsz) begin
                    n.st  = ST_IDLE;
                    n.idx = 9'd0;
                end else begin
                    n.idx = q.idx + 9'd1;
                end
            end
            ST_SEND: begin
                if (indata && !q.dhave) begin
                    if (!q.rdw) begin
                        if (daddr == `CGCH_CTRL_OFS) begin
                            n.dbyte = q.ctrl;
                            n.dhave = 1'b1;
                        end else begin
                            n.rd_req  = 1'b1;
                            n.rd_addr = daddr;
                            n.rdw     = 1'b1;
                        end
                    end else if (i_rd_valid) begin
                        n.dbyte = i_rd_data;
                        n.dhave = 1'b1;
                        n.rdw   = 1'b0;
                    end
                end else if (fifo_rdy) begin
                    own_push = 1'b1;
                    if (q.idx == 9'd0) begin
                        own_byte = q.rdcnt;
                    end else if (q.idx == 9'd1) begin
                        own_byte = i_dev_addr;
                    end else if (q.idx == 9'd2) begin
                        own_byte = q.raddr[15:8];
                    end else if (q.idx == 9'd3) begin
                        own_byte = q.raddr[7:0];
                    end else if (q.idx == snd_last - 9'd1) begin
                        own_byte = q.ctx[7:0];
                    end else if (q.idx == snd_last) begin
                        own_byte = q.ctx[15:8];
                    end else begin
                        own_byte = q.dbyte;
                    end
                    // CRC bytes stay out of the running value
                    if (q.idx < snd_last - 9'd1) begin
                        n.ctx = ctx_nxt;
                    end
                    n.dhave = 1'b0;
                    if (q.idx == snd_last) begin
                        n.st  = ST_IDLE;
                        n.idx = 9'd0;
                    end else begin
                        n.idx = q.idx + 9'd1;
                    end
                end
            end
            default: begin
            end
        endcase

        // Relay of frames from above, checked on the fly
        if (relay) begin
            n.ucrc = ucrc_nxt;
            if (q.uidx == 9'd0) begin
                n.ulen = 9'({1'b0, i_up_data});
            end
            if (q.uidx == 9'd1) begin
                n.uaddr = i_up_data;
            end
            if (q.uidx != 9'd0 && q.uidx == q.ulen + `CGCH_OVERHEAD) begin
                n.uidx = 9'd0;
                if (ucrc_nxt != 16'h0000) begin
                    n.crc_fault = 1'b1;
                end
                // append after address N+1 has passed
                if (q.wt && q.uaddr == i_dev_addr + 8'd1) begin
                    n.wt = 1'b0;
                    if (ucrc_nxt == 16'h0000) begin
                        n.st  = ST_SEND;
                        n.idx = 9'd0;
                    end
                end
            end else begin
                n.uidx = q.uidx + 9'd1;
            end
        end

        // Command intake
        if (i_cmd_valid) begin
            if (i_cmd_sof) begin
                if (is_group(i_cmd_data)) begin
                    n.st  = ST_HDR;
                    n.req = i_cmd_data[`CGCH_REQ_MSB:`CGCH_REQ_LSB];
                    n.dsz = i_cmd_data[`CGCH_DSZ_MSB:`CGCH_DSZ_LSB];
                    n.idx = 9'd1;
                    n.crx = crx_nxt;
                    n.wt  = 1'b0;
                    n.bad = (i_cmd_from_upper != q.ctrl[`CGCH_DIR_BIT])
                            && (i_cmd_data[`CGCH_REQ_MSB:`CGCH_REQ_LSB] != RQ_RWRITE);
                    n.comm_err = n.bad;
                end else begin
                    n.st = ST_IDLE;
                end
            end else if (q.st == ST_HDR) begin
                n.crx = crx_nxt;
                n.idx = q.idx + 9'd1;
                if (q.idx == 9'd1) begin
                    n.raddr[15:8] = i_cmd_data;
                end else if (q.idx == 9'd2) begin
                    n.raddr[7:0] = i_cmd_data;
                end else if (q.idx < `CGCH_CMD_HDR + nd) begin
                    n.rdcnt = i_cmd_data;
                    n.wbuf[3'(q.idx - `CGCH_CMD_HDR)] = i_cmd_data;
                end
                if (q.idx == cmd_last) begin
                    n.idx = 9'd0;
                    n.st  = ST_IDLE;
                    if (crx_nxt == 16'h0000 && !q.bad) begin
                        if (is_write(q.req)) begin
                            if (q.req != RQ_SWRITE || i_stack_member) begin
                                n.st = ST_EXEC;
                            end
                        end else if (responder) begin
                            // top of chain answers at once
                            if (i_top_of_chain) begin
                                n.st = ST_SEND;
                            end else begin
                                n.wt = 1'b1;
                            end
                        end
                    end
                end
            end
        end

        n.up_rdy = fifo_rdy && (n.st != ST_SEND);
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            q      <= '0;
            q.st   <= ST_IDLE;
            q.ctrl <= `CGCH_CTRL_RST;
        end else begin
            q <= n;
        end
    end

    // =========================================================
    // Outputs
    // =========================================================
    assign o_up_ready  = q.up_rdy;
    assign o_wr_en     = q.wr_en;
    assign o_wr_addr   = q.wr_addr;
    assign o_wr_data   = q.wr_data;
    assign o_rd_req    = q.rd_req;
    assign o_rd_addr   = q.rd_addr;
    assign o_dir_sel   = q.ctrl[`CGCH_DIR_BIT];
    assign o_crc_fault = q.crc_fault;
    assign o_comm_err  = q.comm_err;

endmodule

/* File: tb/cgch_nbr_model.sv */
// Partner model: chain neighbour above and the register space
`timescale 1ns/1ps

module cgch_nbr_model (
    // Clock
    input  wire logic        i_mclk,
    // Responses from the device above
    output logic             o_up_valid,
    output logic [7:0]       o_up_data,
    input  wire logic        i_up_ready,
    // Register space
    input  wire logic        i_rd_req,
    input  wire logic [15:0] i_rd_addr,
    output logic             o_rd_valid,
    output logic [7:0]       o_rd_data
);
    logic [7:0]  txq[$];
    logic [15:0] ra_ff;
    int          lat_ff = 0;
    logic        v;

    initial begin
        o_up_valid = 1'b0;
        o_up_data  = 8'h00;
        o_rd_valid = 1'b0;
        o_rd_data  = 8'h00;
    end

    task automatic push_byte(input logic [7:0] b);
        txq.push_back(b);
    endtask

    // Offer held until taken, random gaps, idle data toggles
    always @(posedge i_mclk) begin
        if (o_up_valid && i_up_ready) begin
            txq.delete(0);
        end
        if (!o_up_valid || i_up_ready) begin
            v = txq.size() > 0 && $urandom % 4 != 0;
            o_up_valid <= v;
            o_up_data  <= v ? txq[0] : ~o_up_data;
        end
    end

    // Answer after one to three cycles
    always @(posedge i_mclk) begin
        o_rd_valid <= 1'b0;
        o_rd_data  <= ~o_rd_data;
        if (i_rd_req) begin
            ra_ff  <= i_rd_addr;
            lat_ff <= 1 + $urandom % 3;
        end else if (lat_ff > 0) begin
            lat_ff <= lat_ff - 1;
            if (lat_ff == 1) begin
                o_rd_valid <= 1'b1;
                o_rd_data  <= ra_ff[7:0] ^ 8'h5a;
            end
        end
    end
endmodule

/* File: tb/cgch_handler_sva.sv */
// Checker of the chain group command handler ports
`timescale 1ns/1ps

module cgch_handler_sva (
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    // Watched inputs
    input  wire logic        i_stack_member,
    input  wire logic        i_cmd_valid,
    input  wire logic        i_cmd_sof,
    input  wire logic [7:0]  i_cmd_data,
    input  wire logic        i_cmd_from_upper,
    input  wire logic        i_rsp_ready,
    // Watched outputs
    input  wire logic        o_rsp_valid,
    input  wire logic [7:0]  o_rsp_data,
    input  wire logic        o_wr_en,
    input  wire logic [15:0] o_wr_addr,
    input  wire logic        o_rd_req,
    input  wire logic        o_dir_sel,
    input  wire logic        o_comm_err
);
    logic       port_err;
    logic       nm_ff;
    logic [3:0] run_ff;

    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    assign port_err = i_cmd_valid && i_cmd_sof && i_cmd_data[7]
        && i_cmd_data[6:4] inside {[3'h2:3'h5]} && (i_cmd_from_upper != o_dir_sel);

    // Non-member stack read pending
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            nm_ff <= 1'b0;
        end else if (i_cmd_valid && i_cmd_sof) begin
            nm_ff <= (i_cmd_data == 8'ha0) && !i_stack_member;
        end
    end

    // Length of a write burst
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            run_ff <= 4'h0;
        end else begin
            run_ff <= o_wr_en ? run_ff + 4'h1 : 4'h0;
        end
    end

    // ==========
    // Assertions
    chk_port_err_flag: assert property (port_err |=> o_comm_err)
        else $error("no error flag for frame on wrong port");
    chk_err_has_cause: assert property (o_comm_err |-> $past(port_err))
        else $error("error flag without wrong-port frame");
    chk_rev_no_err: assert property (
        i_cmd_valid && i_cmd_sof && i_cmd_data == 8'he0 |=> !o_comm_err)
        else $error("reverse write flagged");
    chk_wr_run_max: assert property (o_wr_en |-> run_ff < 4'h8)
        else $error("more than eight writes in a burst");
    chk_wr_addr_step: assert property (
        o_wr_en && $past(o_wr_en) |-> o_wr_addr == $past(o_wr_addr) + 16'h0001)
        else $error("write addresses not consecutive");
    chk_rd_req_pulse: assert property (o_rd_req |=> !o_rd_req)
        else $error("read request longer than one cycle");
    chk_nonmember_silent: assert property (nm_ff |-> !o_rd_req)
        else $error("non-member reads for stack read");
    chk_rsp_hold: assert property (
        o_rsp_valid && !i_rsp_ready |=> o_rsp_valid && $stable(o_rsp_data))
        else $error("response byte dropped while stalled");
    chk_dir_reset: assert property ($fell(i_rst) |-> !o_dir_sel && !o_rsp_valid)
        else $error("direction or response not cleared by reset");

    cover property (o_comm_err);
    cover property ($rose(o_dir_sel));
    cover property (run_ff == 4'h8);
    cover property (o_rsp_valid && !i_rsp_ready);
endmodule

bind cgch_handler cgch_handler_sva u_sva (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_stack_member(i_stack_member),
    .i_cmd_valid(i_cmd_valid), .i_cmd_sof(i_cmd_sof), .i_cmd_data(i_cmd_data),
    .i_cmd_from_upper(i_cmd_from_upper), .i_rsp_ready(i_rsp_ready),
    .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data), .o_wr_en(o_wr_en),
    .o_wr_addr(o_wr_addr), .o_rd_req(o_rd_req), .o_dir_sel(o_dir_sel),
    .o_comm_err(o_comm_err)
);

/* File: tb/cgch_handler_tb.sv */
// Self-checking testbench of the chain group command handler
`timescale 1ns/1ps

module cgch_handler_tb;
    // ==========
    // Signals
    logic        i_mclk = 1'b0, i_rst = 1'b1;
    logic [7:0]  i_dev_addr = 8'h00, i_cmd_data = 8'h00, i_up_data, i_rd_data;
    logic        i_stack_member = 1'b0, i_top_of_chain = 1'b0, i_cmd_valid = 1'b0;
    logic        i_cmd_sof = 1'b0, i_cmd_from_upper = 1'b0, i_rsp_ready = 1'b0;
    logic        i_up_valid, i_rd_valid, o_up_ready, o_rsp_valid, o_wr_en, o_rd_req;
    logic        o_dir_sel, o_crc_fault, o_comm_err, hold = 1'b0;
    logic [7:0]  o_rsp_data, o_wr_data;
    logic [15:0] o_wr_addr, o_rd_addr;
    logic [23:0] wq[$];
    logic [7:0]  rq[$];
    int          n_fail = 0, checked = 0, n_err = 0, n_flt = 0;

    always #5 i_mclk = ~i_mclk;

    cgch_handler #(.FIFO_DEPTH(8)) uut (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_dev_addr(i_dev_addr),
        .i_stack_member(i_stack_member), .i_top_of_chain(i_top_of_chain),
        .i_cmd_valid(i_cmd_valid), .i_cmd_sof(i_cmd_sof), .i_cmd_data(i_cmd_data),
        .i_cmd_from_upper(i_cmd_from_upper), .i_up_valid(i_up_valid),
        .i_up_data(i_up_data), .o_up_ready(o_up_ready), .o_rsp_valid(o_rsp_valid),
        .o_rsp_data(o_rsp_data), .i_rsp_ready(i_rsp_ready), .o_wr_en(o_wr_en),
        .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data), .o_rd_req(o_rd_req),
        .o_rd_addr(o_rd_addr), .i_rd_valid(i_rd_valid), .i_rd_data(i_rd_data),
        .o_dir_sel(o_dir_sel), .o_crc_fault(o_crc_fault), .o_comm_err(o_comm_err)
    );

    cgch_nbr_model u_up (
        .i_mclk(i_mclk), .o_up_valid(i_up_valid), .o_up_data(i_up_data),
        .i_up_ready(o_up_ready), .i_rd_req(o_rd_req), .i_rd_addr(o_rd_addr),
        .o_rd_valid(i_rd_valid), .o_rd_data(i_rd_data)
    );

    // ==========
    // Checking
    task automatic fail(input string m);
        n_fail++;
        $display("unexpected at %0t: %s", $time, m);
    endtask

    task automatic cmp_wr(input logic [23:0] g, input logic [23:0] e);
        checked++;
        if (g !== e) fail($sformatf("write %h, want %h", g, e));
    endtask

    task automatic cmp_rsp(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) fail($sformatf("response byte %h, want %h", g, e));
    endtask

    task automatic cmp_st(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) fail($sformatf("status %0h, want %0h", g, e));
    endtask

    task automatic final_report();
        if (n_fail == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    always @(posedge i_mclk) begin
        if (!i_rst && o_wr_en === 1'b1) begin
            if (wq.size() == 0) fail("write");
            else cmp_wr({o_wr_addr, o_wr_data}, wq.pop_front());
        end
        if (!i_rst && o_rsp_valid === 1'b1 && i_rsp_ready) begin
            if (rq.size() == 0) fail("response byte");
            else cmp_rsp(o_rsp_data, rq.pop_front());
        end
        n_err += (!i_rst && o_comm_err === 1'b1);
        n_flt += (!i_rst && o_crc_fault === 1'b1);
    end

    always @(posedge i_mclk) begin
        i_rsp_ready <= !hold && $urandom % 3 != 0;
    end

    // ==========
    // Stimulus
    // reflected CRC, init ffff
    function automatic logic [15:0] crc_of(input logic [7:0] q[$]);
        logic [15:0] c = 16'hffff;
        foreach (q[i]) begin
            c ^= {8'h00, q[i]};
            for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction

    task automatic send(input logic up, input logic [7:0] f[$], input logic bad);
        logic [15:0] c;
        c = crc_of(f) ^ {15'h0000, bad};
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        foreach (f[i]) begin
            @(posedge i_mclk);
            i_cmd_valid <= 1'b1;
            i_cmd_sof <= (i == 0);
            i_cmd_data <= f[i];
            i_cmd_from_upper <= up;
            @(posedge i_mclk);
            i_cmd_valid <= 1'b0;
            i_cmd_data <= ~f[i];
        end
    endtask

    // size minus one, no device byte
    task automatic wr_cmd(input logic [2:0] rt, input int n, input logic up,
                          input logic exp, input logic bad);
        logic [7:0] f[$];
        logic [7:0] d;
        f = '{{1'b1, rt, 1'b0, 3'(n - 1)}, 8'h03, 8'h00};
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            f.push_back(d);
            if (exp) wq.push_back({16'h0300 + 16'(i), d});
        end
        send(up, f, bad);
        repeat (12) @(posedge i_mclk);
    endtask

    task automatic frame(input logic [7:0] dev, input logic [7:0] cnt,
                         input logic bad, input logic upq);
        logic [7:0] f[$];
        logic [15:0] c;
        f = '{cnt, dev, 8'h05, 8'h68};
        for (int i = 0; i <= cnt; i++) f.push_back((8'h68 + 8'(i)) ^ 8'h5a);
        c = crc_of(f) ^ {15'h0000, bad};
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        foreach (f[i]) begin
            rq.push_back(f[i]);
            if (upq) u_up.push_byte(f[i]);
        end
    endtask

    task automatic cfg(input logic [7:0] dev, input logic mem, input logic top);
        @(posedge i_mclk);
        i_dev_addr <= dev;
        i_stack_member <= mem;
        i_top_of_chain <= top;
    endtask

    task automatic drain();
        for (int k = 0; k < 3000 && rq.size() > 0; k++) @(posedge i_mclk);
        repeat (60) @(posedge i_mclk);
    endtask

    initial begin
        void'($urandom(32'h1c64));
        repeat (20) @(posedge i_mclk);
        i_rst <= 1'b0;
        wr_cmd(3'h5, 4, 1'b0, 1'b1, 1'b0);
        cfg(8'h01, 1'b1, 1'b0);
        for (int n = 1; n <= 8; n++) wr_cmd(3'h3, n, 1'b0, 1'b1, 1'b0);
        cfg(8'h01, 1'b0, 1'b0);
        wr_cmd(3'h3, 8, 1'b0, 1'b0, 1'b0);
        wr_cmd(3'h5, 3, 1'b0, 1'b0, 1'b1);
        wr_cmd(3'h5, 2, 1'b1, 1'b0, 1'b0);
        send(1'b1, '{8'he0, 8'h03, 8'h09, 8'h80}, 1'b0);
        repeat (12) @(posedge i_mclk);
        cmp_st(32'(o_dir_sel), 32'h1);
        wr_cmd(3'h5, 1, 1'b1, 1'b1, 1'b0);
        wr_cmd(3'h5, 2, 1'b0, 1'b0, 1'b0);
        send(1'b0, '{8'he0, 8'h03, 8'h09, 8'h00}, 1'b0);
        repeat (12) @(posedge i_mclk);
        cmp_st(32'(o_dir_sel), 32'h0);
        // address and top set before read
        cfg(8'h02, 1'b1, 1'b1);
        send(1'b0, '{8'ha0, 8'h05, 8'h68, 8'h1f}, 1'b0);
        frame(8'h02, 8'h1f, 1'b0, 1'b0);
        drain();
        cfg(8'h02, 1'b0, 1'b1);
        send(1'b0, '{8'ha0, 8'h05, 8'h68, 8'h1f}, 1'b0);
        drain();
        cfg(8'h03, 1'b0, 1'b0);
        hold <= 1'b1;
        send(1'b0, '{8'hc0, 8'h05, 8'h68, 8'h07}, 1'b0);
        frame(8'h04, 8'h07, 1'b0, 1'b1);
        frame(8'h03, 8'h07, 1'b0, 1'b0);
        repeat (80) @(posedge i_mclk);
        cmp_st(32'(o_up_ready), 32'h0);
        hold <= 1'b0;
        drain();
        cmp_st(32'(o_rsp_valid), 32'h0);
        send(1'b0, '{8'hc0, 8'h05, 8'h68, 8'h01}, 1'b0);
        frame(8'h04, 8'h01, 1'b1, 1'b1);
        drain();
        cmp_st(n_err, 32'h2);
        cmp_st(n_flt, 32'h1);
        cmp_st(wq.size() + rq.size(), 32'h0);
        final_report();
    end

    initial begin
        repeat (30000) @(posedge i_mclk);
        fail("timeout");
        final_report();
    end
endmodule
